// >>> rtl/pulse_timer_map.vh
// Register map, field positions, reset values and timing counts
`ifndef PULSE_TIMER_MAP_VH
`define PULSE_TIMER_MAP_VH

`define ADDR_W 8
`define OFF_CTRL 8'h00
`define OFF_DIV 8'h04
`define OFF_PERIOD 8'h08
`define OFF_DUTY 8'h0C
`define OFF_STATUS 8'h10

`define CTRL_EN 0
`define CTRL_MODE_LO 1
`define CTRL_MODE_HI 2
`define CTRL_EXT 3
`define CTRL_POL 4
`define CTRL_GATE 5

`define MODE_RATE 2'h0
`define MODE_ONE 2'h1
`define MODE_REP 2'h2

`define CTRL_RST 32'h0000_0030
`define DIV_RST 32'h0000_0064
`define PERIOD_RST 32'h0000_000A
`define DUTY_RST 32'h0000_0005

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`define CLK_HZ 100000000
`define MAX_OUT_HZ 18000000
`define MIN_OUT_CYC ((`CLK_HZ + `MAX_OUT_HZ - 1) / `MAX_OUT_HZ)
`define MIN_PERIOD 2
`define MIN_DIV ((`MIN_OUT_CYC + `MIN_PERIOD - 1) / `MIN_PERIOD)

`endif

// >>> rtl/pulse_timer.v
// Counter channel with rate, one-shot and repetitive one-shot outputs
// Operation
// - Rate mode: pulse train while gate active
// - Rate mode: stop at once when gate drops
// - Period from divided internal or external clock
// - Output frequency limited to 18 MHz on the internal source; external clock ticks bypass the divider
// - Rate: source, divider, polarity, duty, level gate
// - One-shot: single pulse on selected gate edge
// - After one-shot, ignore everything until restart
// - One-shot: source, divider, polarity, edge gate
// - One-shot modes force full duty cycle
// - Repetitive: one pulse per qualifying gate edge
// - Repetitive runs until software stops it
// - Gate edges during pulse are dropped
// - Repetitive: polarity, source, divider, edge gate
// - Output polarity chosen by software
`timescale 1ns/100ps
`include "pulse_timer_map.vh"

module pulse_timer
(
	input wire clk,
	input wire rst,
	input wire gate_pin,
	input wire ext_clk_pin,
	output reg pulse_out_q,
	input wire [`ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [`ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);

	localparam [2:0] S_IDLE = 3'h0;
	localparam [2:0] S_ARM = 3'h1;
	localparam [2:0] S_PULSE = 3'h2;
	localparam [2:0] S_DONE = 3'h3;
	localparam [2:0] S_RATE = 3'h4;
	localparam [31:0] MIN_DIV = `MIN_DIV;
	localparam [31:0] MIN_PERIOD = `MIN_PERIOD;
	reg [31:0] ctrl_q;
	reg [31:0] div_q;
	reg [31:0] period_q;
	reg [31:0] duty_q;
	reg restart_q;
	reg aw_full_q;
	reg w_full_q;
	reg [`ADDR_W-1:0] waddr_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	reg gate_s1_q;
	reg gate_s2_q;
	reg gate_s3_q;
	reg ext_s1_q;
	reg ext_s2_q;
	reg ext_s3_q;
	reg [31:0] dcnt_q;
	reg [31:0] cnt_q;
	reg [2:0] st_q;
	reg [2:0] st_d;
	reg phase_clr;
	wire [31:0] wmask;
	wire [1:0] mode;
	wire pol;
	wire gate_sel;
	wire [31:0] div_lim;
	wire [31:0] per_lim;
	wire int_tick;
	wire ext_tick;
	wire tick;
	wire gate_ok;
	wire gate_edge;
	wire active;
	wire [`ADDR_W-1:0] wword;
	wire [`ADDR_W-1:0] rword;
	wire [31:0] ctrl_new;
	genvar i;
	generate
		for (i = 0; i < 4; i = i + 1)
		begin : g_mask
			assign wmask[8*i+7:8*i] = {8{wstrb_q[i]}};
		end
	endgenerate
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [31:0] m;
		begin
			merge = (old & ~m) | (nw & m);
		end
	endfunction
	assign ctrl_new = merge(ctrl_q, wdata_q, wmask);
	assign wword = {waddr_q[`ADDR_W-1:2], 2'h0};
	assign rword = {s_axi_araddr[`ADDR_W-1:2], 2'h0};
	assign mode = ctrl_q[`CTRL_MODE_HI:`CTRL_MODE_LO];
	assign pol = ctrl_q[`CTRL_POL];
	assign gate_sel = ctrl_q[`CTRL_GATE];

	// Minimum divider and period keep the internal-source output at or under 18 MHz
	assign div_lim = (div_q < MIN_DIV) ? MIN_DIV : div_q;
	assign per_lim = (period_q < MIN_PERIOD) ? MIN_PERIOD : period_q;
	assign int_tick = (dcnt_q == div_lim - 32'h0000_0001);
	assign ext_tick = ext_s2_q & ~ext_s3_q;
	assign tick = ctrl_q[`CTRL_EXT] ? ext_tick : int_tick;
	// Level gate: 1 = high active, 0 = low active
	assign gate_ok = (gate_s2_q == gate_sel);
	// Edge gate: 1 = rising, 0 = falling
	assign gate_edge = gate_sel ? (gate_s2_q & ~gate_s3_q)
		: (~gate_s2_q & gate_s3_q);
	// Gate term kept here so the train drops without waiting on state
	assign active = ((st_q == S_RATE) && gate_ok && (cnt_q < duty_q))
		|| (st_q == S_PULSE);
	// Synchronisers; only stage two and three feed logic
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			gate_s1_q <= 1'b0;
			gate_s2_q <= 1'b0;
			gate_s3_q <= 1'b0;
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
			ext_s3_q <= 1'b0;
		end
		else
		begin
			gate_s1_q <= gate_pin;
			gate_s2_q <= gate_s1_q;
			gate_s3_q <= gate_s2_q;
			ext_s1_q <= ext_clk_pin;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
		end
	end
	always @*
	begin
		st_d = st_q;
		phase_clr = 1'b0;
		case (st_q)
			S_IDLE:
				st_d = S_IDLE;
			S_ARM:
				if (mode == `MODE_RATE)
				begin
					if (gate_ok)
					begin
						st_d = S_RATE;
						phase_clr = 1'b1;
					end
				end
				else if (gate_edge)
				begin
					st_d = S_PULSE;
					phase_clr = 1'b1;
				end
			S_RATE:
				if (!gate_ok)
					st_d = S_ARM;
			S_PULSE:
				if (tick && (cnt_q == per_lim - 32'h0000_0001))
				begin
					if (mode == `MODE_ONE)
						st_d = S_DONE;
					else
						st_d = S_ARM;
				end
			S_DONE:
				st_d = S_DONE;
			default:
				st_d = S_IDLE;
		endcase
		if (!ctrl_q[`CTRL_EN])
			st_d = S_IDLE;
		else if (restart_q)
		begin
			st_d = S_ARM;
			phase_clr = 1'b0;
		end
	end
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			st_q <= S_IDLE;
			dcnt_q <= 32'h0000_0000;
			cnt_q <= 32'h0000_0000;
			pulse_out_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			if (phase_clr || int_tick)
				dcnt_q <= 32'h0000_0000;
			else
				dcnt_q <= dcnt_q + 32'h0000_0001;
			if (phase_clr || st_q == S_ARM || st_q == S_IDLE)
				cnt_q <= 32'h0000_0000;
			else if (tick)
			begin
				if (cnt_q == per_lim - 32'h0000_0001)
					cnt_q <= 32'h0000_0000;
				else
					cnt_q <= cnt_q + 32'h0000_0001;
			end
			// Gate edges in S_PULSE are never looked at, so none queue
			pulse_out_q <= active ? pol : ~pol;
		end
	end

	// Register write path; address and data may arrive in either order
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			waddr_q <= {`ADDR_W{1'b0}};
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			restart_q <= 1'b0;
			ctrl_q <= `CTRL_RST;
			div_q <= `DIV_RST;
			period_q <= `PERIOD_RST;
			duty_q <= `DUTY_RST;
		end
		else
		begin
			restart_q <= 1'b0;
			if (s_axi_awready && s_axi_awvalid)
			begin
				s_axi_awready <= 1'b0;
				aw_full_q <= 1'b1;
				waddr_q <= s_axi_awaddr;
			end
			else if (!aw_full_q && !s_axi_awready)
				s_axi_awready <= 1'b1;
			if (s_axi_wready && s_axi_wvalid)
			begin
				s_axi_wready <= 1'b0;
				w_full_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			else if (!w_full_q && !s_axi_wready)
				s_axi_wready <= 1'b1;
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (aw_full_q && w_full_q && !s_axi_bvalid)
			begin
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `RESP_OKAY;
				case (wword)
					`OFF_CTRL:
					begin
						ctrl_q <= ctrl_new;
						// Writing enable again re-arms a finished one-shot
						restart_q <= ctrl_new[`CTRL_EN];
					end
					`OFF_DIV:
						div_q <= merge(div_q, wdata_q, wmask);
					`OFF_PERIOD:
						period_q <= merge(period_q, wdata_q, wmask);
					`OFF_DUTY:
						duty_q <= merge(duty_q, wdata_q, wmask);
					`OFF_STATUS:
						s_axi_bresp <= `RESP_OKAY;
					default:
						s_axi_bresp <= `RESP_SLVERR;
				endcase
			end
		end
	end

	// Register read path; answer one cycle after the address is taken
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `RESP_OKAY;
		end
		else
		begin
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			if (s_axi_arready && s_axi_arvalid)
			begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `RESP_OKAY;
				case (rword)
					`OFF_CTRL:
						s_axi_rdata <= ctrl_q;
					`OFF_DIV:
						s_axi_rdata <= div_q;
					`OFF_PERIOD:
						s_axi_rdata <= period_q;
					`OFF_DUTY:
						s_axi_rdata <= duty_q;
					`OFF_STATUS:
						s_axi_rdata <= {28'h000_0000, gate_s2_q,
							st_q == S_DONE, pulse_out_q == pol,
							st_q != S_IDLE && st_q != S_DONE};
					default:
					begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= `RESP_SLVERR;
					end
				endcase
			end
			else if (!s_axi_rvalid && !s_axi_arready)
				s_axi_arready <= 1'b1;
		end
	end

endmodule

// >>> test/pulse_far_end.sv
// Far-side model: gate source and external counting clock
`timescale 1ns/100ps
module pulse_far_end
(
	input wire gate_req,
	input wire ext_run,
	output reg gate_pin,
	output reg ext_clk_pin
);
initial
begin
	gate_pin = 1'h0;
	ext_clk_pin = 1'h0;
end
// Skewed off the clock edge so syncing is exercised
always @(gate_req)
	gate_pin <= #3 gate_req;
// Stands still outside a run
always #30 ext_clk_pin = ext_run ? ~ext_clk_pin : 1'h0;
endmodule

// >>> test/pulse_timer_assertions.sv
// Register bus checks on the pulse timer ports
`timescale 1ns/100ps
module pulse_timer_checks
(
	input wire clk,
	input wire rst,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	input wire s_axi_rready
);
default clocking @(posedge clk); endclocking
default disable iff (rst);
wire aw_t = s_axi_awvalid && s_axi_awready;
wire w_t = s_axi_wvalid && s_axi_wready;
wire ar_t = s_axi_arvalid && s_axi_arready;
wr_resp_a: assert property (aw_t && w_t |=> ##1 s_axi_bvalid)
	else $error("write response late");
wr_err_a: assert property (aw_t && w_t && s_axi_awaddr > 8'h13
	|=> ##1 s_axi_bresp == 2'h2) else $error("write slverr missing");
b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
	|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
aw_block_a: assert property (aw_t |=> !s_axi_awready)
	else $error("write address taken twice");
w_block_a: assert property (w_t |=> !s_axi_wready)
	else $error("write data taken twice");
rd_lat_a: assert property (ar_t |=> s_axi_rvalid)
	else $error("read data late");
rd_err_a: assert property (ar_t && s_axi_araddr > 8'h13
	|=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
	else $error("read slverr missing");
r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
	|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
	else $error("read taken early");
endmodule
bind pulse_timer pulse_timer_checks pulse_timer_checks_i (.clk(clk),
	.rst(rst), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// >>> test/tb_pulse_timer.sv
// Self-checking bench for the pulse timer
`timescale 1ns/100ps
`include "pulse_timer_map.vh"
module tb_pulse_timer;
reg clk = 1'h0;
reg rst = 1'h1;
reg gate_req = 1'h0;
reg ext_run = 1'h0;
reg [7:0] awa = 8'h00;
reg [7:0] ara = 8'h00;
reg [31:0] wd = 32'h0000_0000;
reg awv = 1'h0;
reg wv = 1'h0;
reg bre = 1'h0;
reg arv = 1'h0;
reg rre = 1'h0;
wire gate_pin, ext_clk_pin, pout, awr, wrd, bv, arr, rv;
wire [1:0] bresp;
wire [1:0] rresp;
wire [31:0] rdata;
integer miscompares = 0;
integer n_checks = 0;
integer seed = 32'hae46;
integer i, j, k, w, g;
reg [31:0] m [0:3];
reg [31:0] d;
reg [1:0] r;
always #5 clk = ~clk;
pulse_timer pulse_timer_i (.clk(clk), .rst(rst), .gate_pin(gate_pin),
	.ext_clk_pin(ext_clk_pin), .pulse_out_q(pout), .s_axi_awaddr(awa),
	.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
	.s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd),
	.s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bre),
	.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
	.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
	.s_axi_rready(rre));
pulse_far_end pulse_far_end_i (.gate_req(gate_req), .ext_run(ext_run),
	.gate_pin(gate_pin), .ext_clk_pin(ext_clk_pin));
task chk(input [31:0] s, input [31:0] e);
begin
	n_checks = n_checks + 1;
	if (s !== e)
	begin
		miscompares = miscompares + 1;
		$display("MISMATCH %0t got %h want %h", $time, s, e);
	end
end
endtask
task close_out;
begin
	if (miscompares == 0 && n_checks > 0)
		$display("SIMULATION PASSED");
	else
		$display("SIMULATION FAILED");
	$finish;
end
endtask
task wr(input [7:0] a, input [31:0] v);
begin
	@(posedge clk);
	awa <= a;
	wd <= v;
	awv <= 1'h1;
	wv <= 1'h1;
	for (i = 0; i < 60; i = i + 1)
	begin
		@(posedge clk);
		if (bre && bv)
		begin
			r = bresp;
			i = 99;
		end
		else
		begin
			if (awr) awv <= 1'h0;
			if (wrd) wv <= 1'h0;
			// Ready rises once address and data are both sent, in the same cycle as the response
			if (!awv && !wv) bre <= 1'h1;
		end
	end
	bre <= 1'h0;
	if (i < 100) chk(0, 1);
	if (i < 100) close_out;
end
endtask
task rd(input [7:0] a);
begin
	@(posedge clk);
	ara <= a;
	arv <= 1'h1;
	for (i = 0; i < 60; i = i + 1)
	begin
		@(posedge clk);
		if (rre && rv)
		begin
			d = rdata;
			r = rresp;
			i = 99;
		end
		else
		begin
			if (arr) arv <= 1'h0;
			if (!arv) rre <= 1'h1;
		end
	end
	rre <= 1'h0;
	if (i < 100) chk(0, 1);
	if (i < 100) close_out;
end
endtask
// Width of next active phase, then idle gap (capped at 40)
task meas(input a);
begin
	w = 0;
	g = 0;
	for (j = 0; j < 100 && pout !== a; j = j + 1)
		@(posedge clk);
	while (pout === a && w < 100)
	begin
		@(posedge clk);
		w = w + 1;
	end
	while (pout !== a && g < 40)
	begin
		@(posedge clk);
		g = g + 1;
	end
end
endtask
initial
begin
	m[0] = `CTRL_RST;
	m[1] = `DIV_RST;
	m[2] = `PERIOD_RST;
	m[3] = `DUTY_RST;
	repeat (16) @(posedge clk);
	rst <= 1'h0;
	for (k = 0; k < 4; k = k + 1)
	begin
		rd({k[5:0], 2'h0});
		chk(d, m[k]);
		chk(r, `RESP_OKAY);
		if (k > 0)
		begin
			d = $random(seed);
			m[k] = {24'h00_0000, d[7:0]};
			wr({k[5:0], 2'h0}, m[k]);
			rd({k[5:0], 2'h0});
			chk(d, m[k]);
		end
	end
	wr(8'h20, 32'h0000_0001);
	chk(r, `RESP_SLVERR);
	rd(8'h20);
	chk(r, `RESP_SLVERR);
	wr(8'h04, 32'h0000_0003);
	wr(8'h08, 32'h0000_0004);
	wr(8'h0c, 32'h0000_0001);
	for (k = 0; k < 2; k = k + 1)
	begin
		wr(8'h00, {26'h0, k[0], k[0], 4'h1});
		gate_req <= k[0];
		meas(k[0]);
		meas(k[0]);
		chk(w, 3);
		chk(g, 9);
		gate_req <= ~k[0];
		repeat (6) @(posedge clk);
		meas(k[0]);
		chk(w, 0);
	end
	wr(8'h00, 32'h0000_0033);
	gate_req <= 1'h1;
	meas(1'h1);
	chk(w, 12);
	gate_req <= 1'h0;
	repeat (4) @(posedge clk);
	gate_req <= 1'h1;
	meas(1'h1);
	chk(w, 0);
	rd(`OFF_STATUS);
	chk(d, 32'h0000_000c);
	wr(8'h00, 32'h0000_0015);
	gate_req <= 1'h0;
	fork
		meas(1'h1);
		begin
			repeat (8) @(posedge clk);
			gate_req <= 1'h1;
			repeat (2) @(posedge clk);
			gate_req <= 1'h0;
		end
	join
	chk(w, 12);
	chk(g, 40);
	gate_req <= 1'h1;
	repeat (4) @(posedge clk);
	gate_req <= 1'h0;
	meas(1'h1);
	chk(w, 12);
	wr(8'h00, 32'h0000_003b);
	ext_run <= 1'h1;
	gate_req <= 1'h1;
	meas(1'h1);
	chk(w > 16 && w < 26, 1);
	ext_run <= 1'h0;
	close_out;
end
endmodule
